// ==== inc/sdcg_pkg.sv ====
// Purpose: shared constants and types of the SDRAM command core
// Assumes: 200 MHz core clock, one clock domain
// Notes: mode field layout on the address pins is local to this core
`default_nettype none
package sdcg_pkg;
    // Array geometry
    localparam int BANKS = 4;
    localparam int BANK_W = 2;
    localparam int ROW_W = 12;
    localparam int COL_W = 8;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int MASK_W = 2;
    localparam int MEM_AW = BANK_W + ROW_W + COL_W;
    localparam int AUTOCLOSE_BIT = 10;
    localparam int WBUF_DEPTH = 32;
    // Mode fields on the address pins at mode load
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BT_BIT = 3;
    localparam int MODE_CL_LSB = 4;
    localparam logic [2:0] BL_CODE_1 = 3'h0;
    localparam logic [2:0] BL_CODE_2 = 3'h1;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [2:0] BL_CODE_FULL = 3'h7;
    localparam logic [2:0] CL_CODE_3 = 3'h3;
    localparam logic [2:0] MODE_BL_RESET = 3'h0;
    localparam logic MODE_BT_RESET = 1'b0;
    localparam logic [2:0] MODE_CL_RESET = 3'h2;
    // Self refresh pacing
    localparam int REFRESH_PERIOD_MS = 64;
    localparam int REFRESH_ROWS = 4096;
    localparam int CLK_MHZ = 200;
    localparam int SREF_TICK_CYCLES = (REFRESH_PERIOD_MS * 1000 * CLK_MHZ) / REFRESH_ROWS;
    localparam int SREF_CNT_W = 12;

    typedef enum logic [1:0] {SDCG_RUN, SDCG_PDOWN, SDCG_SREF} sdcg_state_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sdcg_cmd_t;

    typedef struct packed {
        logic [2:0] bl;
        logic bt;
        logic [2:0] cl;
    } sdcg_mode_t;

    typedef struct packed {
        logic [MEM_AW-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [MASK_W-1:0] be;
    } sdcg_wbeat_t;
endpackage
`default_nettype wire

// ==== design/sdcg_fifo.sv ====
// Purpose: write beat buffer between the pins and the array
// Assumes: single clock, writer stalls on in_ready low
// Notes: a push while full is dropped by the caller's choice
`timescale 1ns/100ps
`default_nettype none
module sdcg_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != DEPTH[PW:0]);
    assign out_valid = (count != '0);
    assign out_data = store[rptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            store[wptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wptr <= (wptr == PW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
            end
            if (pop)
            begin
                rptr <= (rptr == PW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== design/sdcg_mem.sv ====
// Purpose: single port storage array with byte enables
// Assumes: read and write never in the same cycle
// Notes: read data come from a register and hold between reads
`timescale 1ns/100ps
`default_nettype none
module sdcg_mem #(
    parameter int AW = 22,
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Access port
    input wire logic re,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic [DW/8-1:0] wbe,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] cells [0:(2**AW)-1];

    always_ff @(posedge core_clk)
    begin
        if (we)
        begin
            for (int i = 0; i < DW / 8; i++)
            begin
                if (wbe[i])
                begin
                    cells[addr][i*8 +: 8] <= wdata[i*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata <= '0;
        end
        else if (re)
        begin
            rdata <= cells[addr];
        end
    end
endmodule
`default_nettype wire

// ==== design/sdcg_core.sv ====
// Purpose: command level core of a four bank 16 bit SDRAM
// Assumes: controller keeps its timing, all pins synchronous to core_clk
// Notes: write beats pass a buffer; reads take the array port ahead of it
// Behaviour
// - All pins are captured on the rising clock edge, valid there.
// - Four banks of one mebi-word of 16 bits, chosen by two bank pins.
// - Bursts of 1, 2, 4, 8 words or a full page from given column.
// - Burst column order is sequential or interleaved by mode.
// - Read latency of two or three cycles by mode.
// - Burst stop command cuts an ongoing burst short.
// - Autoclose bit closes the row when the burst finishes.
// - Commanded auto refresh and clockless self refresh.
// - Clock enable high runs the internal clock, low stops it.
// - Clock enable low freezes read outputs, open banks and burst from next cycle; the write buffer keeps draining.
// - Power-down or self refresh entered only with all banks idle.
// - Clock enable sensed directly while powered down, until exit.
// - Powered down, every other input is ignored.
// - Activate, read, write and precharge act on the bank their bank pins select, except precharge with the autoclose bit, which closes all banks.
// - Row strobe low, column high: write high opens, low closes.
`timescale 1ns/100ps
`default_nettype none
module sdcg_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Command pins
    input wire logic cke,
    input wire sdcg_pkg::sdcg_cmd_t cmd,
    input wire logic bank_sel_lo,
    input wire logic bank_sel_hi,
    input wire logic [sdcg_pkg::ADDR_W-1:0] addr,
    // Data pins
    input wire logic [sdcg_pkg::DATA_W-1:0] dq_in,
    input wire logic low_byte_mask,
    input wire logic high_byte_mask,
    output logic [sdcg_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    // Status
    output logic [sdcg_pkg::BANKS-1:0] bank_open,
    output logic power_down,
    output logic self_refresh,
    output logic clk_suspended,
    output logic [sdcg_pkg::ROW_W-1:0] refresh_row,
    output logic refresh_tick,
    output logic wbuf_empty,
    output logic wr_accept
);
    import sdcg_pkg::*;

    sdcg_state_t st;
    sdcg_mode_t mode;
    logic cke_q;
    logic active;
    logic cmd_ok;
    logic [BANK_W-1:0] bank_in;
    logic is_act, is_pre, is_rd, is_wr, is_ref, is_mrs, is_bst;
    logic rw_cmd;
    logic all_idle;
    logic [ROW_W-1:0] open_row [0:BANKS-1];
    // Burst state
    logic b_act, b_wr, b_ap, b_full, b_ilv;
    logic [BANK_W-1:0] b_bank;
    logic [COL_W-1:0] b_start;
    logic [COL_W-1:0] b_wmask;
    logic [8:0] b_idx;
    logic [8:0] b_len;
    // Current beat
    logic beat_go, beat_wr, beat_last, ap_close;
    logic [BANK_W-1:0] beat_bank;
    logic [COL_W-1:0] beat_col;
    // Array and buffer
    logic mem_re, mem_we;
    logic [MEM_AW-1:0] mem_addr;
    logic [DATA_W-1:0] mem_rdata;
    sdcg_wbeat_t wb_in, wb_out;
    logic wb_out_valid;
    // Read pipeline and self refresh pacing
    logic s0_v, s1_v;
    logic [DATA_W-1:0] s1;
    logic [SREF_CNT_W-1:0] sref_cnt;
    logic sref_wrap;

    function automatic logic [8:0] bl_len(input logic [2:0] c);
        case (c)
            BL_CODE_2: bl_len = 9'h002;
            BL_CODE_4: bl_len = 9'h004;
            BL_CODE_8: bl_len = 9'h008;
            BL_CODE_FULL: bl_len = 9'h100;
            default: bl_len = 9'h001;
        endcase
    endfunction

    function automatic logic [COL_W-1:0] bl_wmask(input logic [2:0] c);
        case (c)
            BL_CODE_2: bl_wmask = 8'h01;
            BL_CODE_4: bl_wmask = 8'h03;
            BL_CODE_8: bl_wmask = 8'h07;
            BL_CODE_FULL: bl_wmask = 8'hFF;
            default: bl_wmask = 8'h00;
        endcase
    endfunction

    // Column of beat idx; wrap stays inside the burst-sized block
    function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] start, input logic [8:0] idx,
                                                input logic [COL_W-1:0] wm, input logic ilv);
        logic [COL_W-1:0] sum;
        sum = start + idx[COL_W-1:0];
        if (ilv && wm != 8'hFF)
            col_of = start ^ (idx[COL_W-1:0] & wm);
        else
            col_of = (start & ~wm) | (sum & wm);
    endfunction

    // Pins only count while running with the internal clock on
    assign active = (st == SDCG_RUN) && cke_q;
    assign cmd_ok = active && !cmd.cs_n;
    assign bank_in = {bank_sel_hi, bank_sel_lo};
    assign rw_cmd = is_rd || is_wr;
    assign all_idle = (bank_open == '0) && !b_act;

    always_comb
    begin
        is_act = 1'b0;
        is_pre = 1'b0;
        is_rd = 1'b0;
        is_wr = 1'b0;
        is_ref = 1'b0;
        is_mrs = 1'b0;
        is_bst = 1'b0;
        if (cmd_ok)
        begin
            case ({cmd.ras_n, cmd.cas_n, cmd.we_n})
                3'h3: is_act = 1'b1;
                3'h2: is_pre = 1'b1;
                3'h5: is_rd = 1'b1;
                3'h4: is_wr = 1'b1;
                3'h1: is_ref = 1'b1;
                3'h0: is_mrs = 1'b1;
                3'h6: is_bst = 1'b1;
                default: is_act = 1'b0;
            endcase
        end
    end

    // Current beat: a new command starts at beat 0 in its own cycle
    always_comb
    begin
        beat_go = active && (rw_cmd || (b_act && !is_bst));
        beat_wr = rw_cmd ? is_wr : b_wr;
        beat_bank = rw_cmd ? bank_in : b_bank;
        if (rw_cmd)
        begin
            beat_col = addr[COL_W-1:0];
            beat_last = (bl_len(mode.bl) == 9'h001);
            ap_close = beat_go && beat_last && addr[AUTOCLOSE_BIT];
        end
        else
        begin
            beat_col = col_of(b_start, b_idx, b_wmask, b_ilv);
            beat_last = !b_full && (b_idx + 9'h001 == b_len);
            ap_close = beat_go && beat_last && b_ap;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cke_q <= 1'b0;
        end
        else
        begin
            cke_q <= cke;
        end
    end

    // Power state; exit looks at the raw pin, not the delayed copy
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= SDCG_RUN;
        end
        else
        begin
            case (st)
                SDCG_RUN:
                    if (cke_q && !cke && all_idle)
                        st <= is_ref ? SDCG_SREF : SDCG_PDOWN;
                SDCG_PDOWN, SDCG_SREF:
                    if (cke)
                        st <= SDCG_RUN;
                default: st <= SDCG_RUN;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode <= '{bl: MODE_BL_RESET, bt: MODE_BT_RESET, cl: MODE_CL_RESET};
        end
        else if (is_mrs)
        begin
            mode.bl <= addr[MODE_BL_LSB +: 3];
            mode.bt <= addr[MODE_BT_BIT];
            mode.cl <= addr[MODE_CL_LSB +: 3];
        end
    end

    // Bank rows; an activate in the same cycle wins over an autoclose
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bank_open <= '0;
            for (int i = 0; i < BANKS; i++)
                open_row[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < BANKS; i++)
            begin
                if (ap_close && beat_bank == BANK_W'(i))
                    bank_open[i] <= 1'b0;
                if (is_pre && (addr[AUTOCLOSE_BIT] || bank_in == BANK_W'(i)))
                    bank_open[i] <= 1'b0;
                if (is_act && bank_in == BANK_W'(i))
                begin
                    bank_open[i] <= 1'b1;
                    open_row[i] <= addr[ROW_W-1:0];
                end
            end
        end
    end

    // Burst sequencer; holds still while the internal clock is off
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            b_act <= 1'b0;
            b_wr <= 1'b0;
            b_ap <= 1'b0;
            b_full <= 1'b0;
            b_ilv <= 1'b0;
            b_bank <= '0;
            b_start <= '0;
            b_wmask <= '0;
            b_idx <= '0;
            b_len <= '0;
        end
        else if (rw_cmd)
        begin
            b_act <= !beat_last;
            b_wr <= is_wr;
            b_ap <= addr[AUTOCLOSE_BIT];
            b_full <= (mode.bl == BL_CODE_FULL);
            b_ilv <= mode.bt;
            b_bank <= bank_in;
            b_start <= addr[COL_W-1:0];
            b_wmask <= bl_wmask(mode.bl);
            b_idx <= 9'h001;
            b_len <= bl_len(mode.bl);
        end
        else if (active && b_act)
        begin
            if (is_bst || beat_last)
                b_act <= 1'b0;
            else
                b_idx <= b_idx + 9'h001;
        end
    end

    // Reads take the array port first, so writes back up in the buffer
    assign mem_re = beat_go && !beat_wr;
    assign mem_we = wb_out_valid && !mem_re;
    assign mem_addr = mem_re ? {beat_bank, open_row[beat_bank], beat_col} : wb_out.addr;
    assign wb_in = '{addr: {beat_bank, open_row[beat_bank], beat_col}, data: dq_in,
                     be: {!high_byte_mask, !low_byte_mask}};
    assign wbuf_empty = !wb_out_valid;

    sdcg_fifo #(
        .WIDTH($bits(sdcg_wbeat_t)),
        .DEPTH(WBUF_DEPTH)
    ) u_wbuf (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(beat_go && beat_wr),
        .in_ready(wr_accept),
        .in_data(wb_in),
        .out_valid(wb_out_valid),
        .out_ready(!mem_re),
        .out_data(wb_out)
    );

    sdcg_mem #(
        .AW(MEM_AW),
        .DW(DATA_W)
    ) u_mem (
        .core_clk(core_clk),
        .nrst(nrst),
        .re(mem_re),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(wb_out.data),
        .wbe(wb_out.be),
        .rdata(mem_rdata)
    );

    // Latency 2 skips the middle stage; frozen while suspended
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s0_v <= 1'b0;
            s1_v <= 1'b0;
            s1 <= '0;
            dq_out <= '0;
            dq_oe <= 1'b0;
        end
        else if (active)
        begin
            s0_v <= mem_re;
            s1_v <= s0_v;
            s1 <= mem_rdata;
            if (mode.cl == CL_CODE_3)
            begin
                dq_out <= s1;
                dq_oe <= s1_v;
            end
            else
            begin
                dq_out <= mem_rdata;
                dq_oe <= s0_v;
            end
        end
    end

    // Self refresh paces its own row walk at the retention rate
    assign sref_wrap = (st == SDCG_SREF) && (sref_cnt == SREF_CNT_W'(SREF_TICK_CYCLES - 1));

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sref_cnt <= '0;
            refresh_row <= '0;
            refresh_tick <= 1'b0;
        end
        else
        begin
            if (st != SDCG_SREF || sref_wrap)
                sref_cnt <= '0;
            else
                sref_cnt <= sref_cnt + 1'b1;
            refresh_tick <= (is_ref && cke) || sref_wrap;
            if ((is_ref && cke) || sref_wrap)
                refresh_row <= refresh_row + 1'b1;
        end
    end

    assign power_down = (st == SDCG_PDOWN);
    assign self_refresh = (st == SDCG_SREF);
    assign clk_suspended = (st == SDCG_RUN) && !cke_q;
endmodule
`default_nettype wire

// ==== dv/sdcg_core_chk.sv ====
// Purpose: port level assertions for sdcg_core
// Assumes: one clock, commands taken on the rising edge
// Notes: read latency follows the last mode load seen
`timescale 1ns/100ps
`default_nettype none
module sdcg_core_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Command pins
    input wire logic cke,
    input wire sdcg_pkg::sdcg_cmd_t cmd,
    input wire logic bank_sel_lo,
    input wire logic bank_sel_hi,
    input wire logic [sdcg_pkg::ADDR_W-1:0] addr,
    // Watched outputs
    input wire logic dq_oe,
    input wire logic [sdcg_pkg::DATA_W-1:0] dq_out,
    input wire logic [sdcg_pkg::BANKS-1:0] bank_open,
    input wire logic power_down,
    input wire logic self_refresh,
    input wire logic clk_suspended,
    input wire logic [sdcg_pkg::ROW_W-1:0] refresh_row,
    input wire logic refresh_tick
);
    import sdcg_pkg::*;
    logic live;
    logic cl3;
    logic [1:0] bank;
    logic [2:0] op;
    assign live = cke && !clk_suspended && !power_down && !self_refresh && !cmd.cs_n;
    assign bank = {bank_sel_hi, bank_sel_lo};
    assign op = {cmd.ras_n, cmd.cas_n, cmd.we_n};

    // Mirrors mode loads so the read checks know their delay
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            cl3 <= 1'b0;
        else if (live && op == 3'h0)
            cl3 <= addr[MODE_CL_LSB +: 3] == CL_CODE_3;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_read;
        live && op == 3'h5;
    endsequence
    sequence s_down;
        power_down || self_refresh;
    endsequence

    act_opens_a: assert property (live && op == 3'h3 |=> bank_open[$past(bank)])
        else $error("activate left its bank closed");
    pre_closes_a: assert property (live && op == 3'h2 && !addr[AUTOCLOSE_BIT] |=> !bank_open[$past(bank)])
        else $error("precharge left its bank open");
    pre_all_a: assert property (live && op == 3'h2 && addr[AUTOCLOSE_BIT] |=> bank_open == 4'h0)
        else $error("precharge all left a bank open");
    read_cl2_a: assert property (s_read ##0 !cl3 |-> ##2 dq_oe)
        else $error("read data late at latency two");
    read_cl3_a: assert property (s_read ##0 cl3 ##1 cke |-> ##2 dq_oe)
        else $error("read data late at latency three");
    ref_tick_a: assert property (live && op == 3'h1 |=> refresh_tick)
        else $error("auto refresh gave no tick");
    clk_stop_a: assert property (!cke && !power_down && !self_refresh |=> clk_suspended || power_down || self_refresh)
        else $error("clock enable low did not stop the clock");
    frozen_out_a: assert property (clk_suspended |=> $stable(dq_out) && $stable(dq_oe) && $stable(bank_open))
        else $error("outputs moved while suspended");
    entry_idle_a: assert property ($rose(power_down) || $rose(self_refresh) |-> $past(bank_open) == 4'h0)
        else $error("power saving entered with a bank open");
    down_hold_a: assert property (power_down && !cke |=> power_down && $stable(bank_open) && $stable(refresh_row))
        else $error("input acted on while powered down");
    wake_up_a: assert property (s_down ##0 cke |=> !power_down && !self_refresh)
        else $error("clock enable high did not wake the core");
endmodule

bind sdcg_core sdcg_core_chk u_sdcg_core_chk (.*);
`default_nettype wire

// ==== dv/sdcg_ctrl_model.sv ====
// Purpose: memory controller model driving the command pins
// Assumes: caller runs one task at a time
// Notes: issue turns idle pins round so stale values never look valid
`timescale 1ns/100ps
`default_nettype none
module sdcg_ctrl_model (
    // Clock
    input wire logic core_clk,
    // Command pins
    output logic cke,
    output var sdcg_pkg::sdcg_cmd_t cmd,
    output logic bank_sel_lo,
    output logic bank_sel_hi,
    output logic [sdcg_pkg::ADDR_W-1:0] addr,
    // Write data pins
    output logic [sdcg_pkg::DATA_W-1:0] dq_in,
    output logic low_byte_mask,
    output logic high_byte_mask
);
    import sdcg_pkg::*;
    logic [BANKS-1:0] rows_up = 4'h0;
    logic mode_done = 1'b0;
    initial
    begin
        cke = 1'b1;
        cmd = sdcg_cmd_t'(4'hF);
        {bank_sel_hi, bank_sel_lo, addr, dq_in, high_byte_mask, low_byte_mask} = '0;
    end

    // Changed just after an edge, so stable at the next one
    task automatic issue(input logic [2:0] op, input logic [1:0] b, input logic [11:0] a);
        @(posedge core_clk);
        cmd <= sdcg_cmd_t'({1'b0, op});
        {bank_sel_hi, bank_sel_lo} <= b;
        addr <= a;
        @(posedge core_clk);
        cmd <= sdcg_cmd_t'(4'hF);
        {bank_sel_hi, bank_sel_lo} <= ~b;
        addr <= ~a;
        dq_in <= ~dq_in;
        if (op == 3'h3)
            rows_up[b] <= 1'b1;
        else if (op == 3'h2 && a[AUTOCLOSE_BIT])
            rows_up <= 4'h0;
        else if (op == 3'h2 || (op[2:1] == 2'b10 && a[AUTOCLOSE_BIT]))
            rows_up[b] <= 1'b0;
        if (op == 3'h0)
            mode_done <= 1'b1;
    endtask

    task automatic access(input logic [2:0] op, input logic [1:0] b, input logic [11:0] a);
        if (!mode_done)
            issue(3'h0, 2'h0, 12'h0);
        if (!rows_up[b])
            issue(3'h3, b, 12'h0);
        issue(op, b, a);
    endtask

    // Beat i carries base plus i
    task automatic write_burst(input logic [1:0] b, input logic [11:0] a, input int n, input logic [15:0] base);
        if (!rows_up[b])
            issue(3'h3, b, 12'h0);
        @(posedge core_clk);
        cmd <= sdcg_cmd_t'(4'h4);
        {bank_sel_hi, bank_sel_lo} <= b;
        addr <= a;
        dq_in <= base;
        for (int i = 1; i <= n; i++)
        begin
            @(posedge core_clk);
            cmd <= sdcg_cmd_t'(4'hF);
            dq_in <= (i < n) ? base + 16'(i) : ~dq_in;
        end
    endtask

    task automatic clk_en(input logic v, input logic [2:0] op);
        @(posedge core_clk);
        cke <= v;
        cmd <= sdcg_cmd_t'({1'b0, op});
        @(posedge core_clk);
        cmd <= sdcg_cmd_t'(4'hF);
    endtask
endmodule
`default_nettype wire

// ==== dv/sdcg_core_tb_top.sv ====
// Purpose: scenario bench for sdcg_core
// Assumes: controller model owns every command pin
// Notes: self refresh run waits one full tick period
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) \
begin \
    check_count++; \
    if ((gt) !== (ex)) \
    begin \
        n_errors++; \
        $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); \
    end \
end
module sdcg_core_tb_top;
    import sdcg_pkg::*;
    logic core_clk, nrst, cke, bank_sel_lo, bank_sel_hi, low_byte_mask, high_byte_mask;
    logic dq_oe, power_down, self_refresh, clk_suspended, refresh_tick, wbuf_empty, wr_accept;
    sdcg_cmd_t cmd;
    logic [11:0] addr, refresh_row;
    logic [15:0] dq_in, dq_out;
    logic [3:0] bank_open;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;

    sdcg_core u_sdcg_core (.*);
    sdcg_ctrl_model u_sdcg_ctrl_model (.*);

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic conclude();
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            n_errors++;
            conclude();
        end
    end

    // Samples after the edge's updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic rd_chk(input int cl, input int n, input logic [7:0] s, input logic [7:0] m, input logic ilv);
        int k;
        logic [7:0] c;
        u_sdcg_ctrl_model.access(3'h5, 2'h2, {4'h0, s});
        #1;
        for (k = 0; k < 8 && dq_oe !== 1'b1; k++)
            tick(1);
        `CHK("latency", cl - 1, k)
        for (int i = 0; i < n; i++)
        begin
            c = ilv ? s ^ (8'(i) & m) : (s & ~m) | ((s + 8'(i)) & m);
            `CHK("beat", {8'h5A, c}, dq_out)
            tick(1);
        end
        `CHK("burst end", 1'b0, dq_oe)
    endtask

    task automatic t_banks();
        for (int b = 0; b < BANKS; b++)
        begin
            u_sdcg_ctrl_model.issue(3'h3, 2'(b), 12'h0);
            #1;
            `CHK("activate", 4'hF >> (3 - b), bank_open)
        end
        u_sdcg_ctrl_model.issue(3'h2, 2'h1, 12'h0);
        #1;
        `CHK("precharge", 4'hD, bank_open)
        u_sdcg_ctrl_model.issue(3'h2, 2'h0, 12'h400);
        #1;
        `CHK("precharge all", 4'h0, bank_open)
    endtask

    task automatic t_data();
        u_sdcg_ctrl_model.issue(3'h0, 2'h0, 12'h003);
        u_sdcg_ctrl_model.write_burst(2'h2, 12'h0, 8, 16'h5A00);
        for (int i = 0; i < 40 && wbuf_empty !== 1'b1; i++)
            tick(1);
        `CHK("drained", 1'b1, wbuf_empty)
        `CHK("accept", 1'b1, wr_accept)
        for (int t = 0; t < 8; t++)
        begin
            u_sdcg_ctrl_model.issue(3'h0, 2'h0, {5'h0, 3'h2, t[2], 1'b0, t[1:0]});
            rd_chk(2, 1 << t[1:0], 8'h5, 8'((1 << t[1:0]) - 1), t[2]);
        end
        u_sdcg_ctrl_model.issue(3'h0, 2'h0, 12'h03B);
        rd_chk(3, 8, 8'h5, 8'h7, 1'b1);
    endtask

    task automatic t_stop_close();
        u_sdcg_ctrl_model.issue(3'h0, 2'h0, 12'h007);
        u_sdcg_ctrl_model.access(3'h5, 2'h2, 12'h005);
        u_sdcg_ctrl_model.issue(3'h6, 2'h2, 12'h0);
        tick(6);
        `CHK("stopped", 1'b0, dq_oe)
        u_sdcg_ctrl_model.issue(3'h0, 2'h0, 12'h002);
        u_sdcg_ctrl_model.access(3'h5, 2'h2, 12'h405);
        #1;
        `CHK("open in burst", 1'b1, bank_open[2])
        tick(5);
        `CHK("autoclosed", 1'b0, bank_open[2])
    endtask

    task automatic t_suspend();
        logic [15:0] v;
        u_sdcg_ctrl_model.issue(3'h0, 2'h0, 12'h003);
        u_sdcg_ctrl_model.access(3'h5, 2'h2, 12'h0);
        tick(1);
        u_sdcg_ctrl_model.clk_en(1'b0, 3'h7);
        tick(1);
        v = dq_out;
        repeat (4)
        begin
            tick(1);
            `CHK("frozen", v, dq_out)
            `CHK("suspended", 1'b1, clk_suspended)
        end
        u_sdcg_ctrl_model.clk_en(1'b1, 3'h7);
        for (int i = 0; i < 8 && dq_out === v; i++)
            tick(1);
        `CHK("resumed", v + 16'h1, dq_out)
        tick(10);
    endtask

    task automatic t_power();
        logic [11:0] r;
        int n;
        u_sdcg_ctrl_model.issue(3'h2, 2'h0, 12'h400);
        r = refresh_row;
        u_sdcg_ctrl_model.issue(3'h1, 2'h0, 12'h0);
        #1;
        `CHK("refresh tick", 1'b1, refresh_tick)
        tick(2);
        `CHK("refresh row", r + 12'h1, refresh_row)
        u_sdcg_ctrl_model.clk_en(1'b0, 3'h7);
        tick(1);
        `CHK("power down", 1'b1, power_down)
        u_sdcg_ctrl_model.issue(3'h3, 2'h1, 12'h0);
        tick(1);
        `CHK("ignored", 4'h0, bank_open)
        u_sdcg_ctrl_model.clk_en(1'b1, 3'h7);
        tick(1);
        `CHK("woken", 1'b0, power_down)
        u_sdcg_ctrl_model.clk_en(1'b0, 3'h1);
        tick(1);
        `CHK("self refresh", 1'b1, self_refresh)
        n = 0;
        repeat (3200)
        begin
            tick(1);
            n += (refresh_tick === 1'b1);
        end
        `CHK("self ticks", 1'b1, n > 0)
        u_sdcg_ctrl_model.clk_en(1'b1, 3'h7);
        tick(1);
        `CHK("left self refresh", 1'b0, self_refresh)
        u_sdcg_ctrl_model.issue(3'h3, 2'h0, 12'h0);
        u_sdcg_ctrl_model.clk_en(1'b0, 3'h7);
        tick(1);
        `CHK("busy no power down", 2'h1, {power_down, clk_suspended})
        u_sdcg_ctrl_model.clk_en(1'b1, 3'h7);
        u_sdcg_ctrl_model.issue(3'h2, 2'h0, 12'h400);
    endtask

    initial
    begin
        nrst = 1'b0;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_banks();
        t_data();
        t_stop_close();
        t_suspend();
        t_power();
        conclude();
    end
endmodule
`default_nettype wire
